// *** verilog/flpc_pkg.sv ***
// constants and types shared by the fifo level and power control block
package flpc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_RX_DATAPATH_CONTROL = 8'h78;
   localparam logic [7:0] OFS_RX_FIFO_OCCUPANCY = 8'h7c;
   localparam logic [7:0] OFS_TX_FIFO_OCCUPANCY = 8'h80;
   localparam logic [7:0] OFS_POWER_MANAGEMENT_CONTROL = 8'h84;
   localparam logic [7:0] OFS_ENDIAN_PROBE = 8'h64;
   // field positions
   localparam int BIT_RX_SKIP_FRAME = 31;
   localparam int LSB_STATUS_FILL = 16;
   localparam int LSB_POWER_STATE_SELECT = 12;
   localparam int BIT_TRANSCEIVER_RESET = 10;
   localparam int BIT_WAKE_FRAME_ENABLE = 9;
   localparam int BIT_ENERGY_DETECT_ENABLE = 8;
   localparam int BIT_WAKE_OUTPUT_DRIVE_TYPE = 6;
   localparam int BIT_WAKE_OUTPUT_PULSE_SELECT = 3;
   localparam int BIT_WAKE_OUTPUT_POLARITY = 2;
   localparam int BIT_WAKE_OUTPUT_ENABLE = 1;
   localparam int BIT_DEVICE_READY = 0;
   // values after reset
   localparam logic [7:0] RST_STATUS_FILL = 8'h00;
   localparam logic [15:0] RST_RX_DATA_FILL = 16'h0000;
   localparam logic [15:0] RST_TX_DATA_ROOM = 16'h1200;
   localparam logic [15:0] FILL_WORD_BYTES = 16'h0004;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int XCVR_RESET_MIN_NS = 100000;
   localparam int XCVR_RESET_CYC = (XCVR_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_PULSE_MS = 50;
   localparam int WAKE_PULSE_CYC = (WAKE_PULSE_MS * 1000000) / CLK_PERIOD_NS;
   localparam int SETTLE_CYC = 16;
   localparam logic [4:0] SETTLE_CNT_MAX = 5'h10;
   // power states
   typedef enum logic [1:0] {
      FLPC_PM_NORMAL = 2'b00,
      FLPC_PM_WAKE_FRAME = 2'b01,
      FLPC_PM_ENERGY = 2'b10,
      FLPC_PM_RSVD = 2'b11
   } flpc_pm_e;
endpackage

// *** verilog/flpc_wake_if.sv ***
// wake output controls and results between the register bank and the wake logic
interface flpc_wake_if;
   logic ev_frame;
   logic ev_energy;
   logic frame_en;
   logic energy_en;
   logic out_en;
   logic pulse_sel;
   logic polarity;
   logic push_pull;
   logic pin_level;
   logic pin_oe;
   logic irq;
   modport ctl (output ev_frame, ev_energy, frame_en, energy_en, out_en, pulse_sel, polarity, push_pull,
      input pin_level, pin_oe, irq);
   modport wake (input ev_frame, ev_energy, frame_en, energy_en, out_en, pulse_sel, polarity, push_pull,
      output pin_level, pin_oe, irq);
endinterface

// *** verilog/flpc_hold_timer.sv ***
// one-shot timer: busy for exactly CYCLES clock cycles after a start
module flpc_hold_timer #(
   parameter int CYCLES = 16
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   output logic busy_out
);
   logic [31:0] cnt_r;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= 32'h0;
         busy_out <= 1'b0;
      end else if (start_in && !busy_out) begin
         cnt_r <= 32'(CYCLES - 1);
         busy_out <= 1'b1;
      end else if (busy_out) begin
         if (cnt_r == 32'h0) begin
            busy_out <= 1'b0;
         end else begin
            cnt_r <= cnt_r - 32'h1;
         end
      end
   end
endmodule // flpc_hold_timer

// *** verilog/flpc_wake.sv ***
// wake event latching, pulse stretching and pin drive
module flpc_wake #(
   parameter int PULSE_CYC = 5000000
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   flpc_wake_if.wake wif
);
   logic frame_lat_r;
   logic energy_lat_r;
   logic new_event;
   logic pulse_busy;
   logic assert_lvl;

   assign new_event = (wif.ev_frame && wif.frame_en) || (wif.ev_energy && wif.energy_en);

   // events stick until their enable is cleared
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         frame_lat_r <= 1'b0;
         energy_lat_r <= 1'b0;
      end else begin
         frame_lat_r <= wif.frame_en && (frame_lat_r || wif.ev_frame);
         energy_lat_r <= wif.energy_en && (energy_lat_r || wif.ev_energy);
      end
   end

   flpc_hold_timer #(.CYCLES(PULSE_CYC)) u_pulse (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .start_in(new_event && wif.pulse_sel),
      .busy_out(pulse_busy)
   );

   assign assert_lvl = wif.out_en && (wif.pulse_sel ? pulse_busy : (frame_lat_r || energy_lat_r));

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wif.pin_level <= 1'b0;
         wif.pin_oe <= 1'b0;
         wif.irq <= 1'b0;
      end else begin
         wif.irq <= frame_lat_r || energy_lat_r;
         if (wif.push_pull) begin
            wif.pin_oe <= 1'b1;
            wif.pin_level <= wif.polarity ? assert_lvl : !assert_lvl;
         end else begin
            wif.pin_oe <= assert_lvl;
            wif.pin_level <= 1'b0;
         end
      end
   end
endmodule // flpc_wake

// *** verilog/flpc_top.sv ***
// register bank for receive skip, fifo fill levels and power management
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - writing one to the skip bit advances rx data reads to the next frame
// - skip bit reads one while the skip runs, then clears itself
// - rx status fill counts occupied status words, zero after reset
// - rx data fill counts bytes; each frame adds its length rounded to words
// - tx status fill counts occupied tx status words
// - tx data room shows free tx data bytes, 1200h after reset
// - power state select: 00 normal, 01 wake frame, 10 energy; self-clearing
// - any write to the endian probe wakes a sleeping device
// - writes are ignored until a read follows reset or wake
// - transceiver reset bit resets the transceiver for at least 100us
// - transceiver reset bit clears itself when the reset ends
// - writes to the transceiver reset bit are ignored while it reads one
// - enabled wake frame events drive the wake output per enable and pulse mode
// - enabled wake frame events raise the wake interrupt regardless of output enable
// - enabled energy events drive the wake output per enable and pulse mode and raise the interrupt regardless of output enable
// - drive type clear gives open-drain active low; set gives push-pull
// - power management control stays readable in every power state
// - pulse select set gives a 50ms pulse; clear holds the output
// - wake output enable gates only the pin, not the interrupt
// - in push-pull, polarity set gives active high, clear active low; open-drain ignores it
module flpc_top
   import flpc_pkg::*;
#(
   parameter int XRST_CYC = flpc_pkg::XCVR_RESET_CYC,
   parameter int PULSE_CYC = flpc_pkg::WAKE_PULSE_CYC
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic rx_frame_in,
   input wire logic [15:0] rx_frame_len_in,
   input wire logic rx_data_pop_in,
   input wire logic rx_status_push_in,
   input wire logic rx_status_pop_in,
   input wire logic tx_data_push_in,
   input wire logic tx_data_drain_in,
   input wire logic tx_status_push_in,
   input wire logic tx_status_pop_in,
   output logic rx_skip_req_out,
   input wire logic rx_skip_done_in,
   input wire logic [15:0] rx_skip_len_in,
   input wire logic wake_frame_event_in,
   input wire logic energy_event_in,
   output logic wake_pin_out,
   output logic wake_pin_oe_out,
   output logic wake_interrupt_out,
   output logic transceiver_reset_out,
   output logic [1:0] power_state_out,
   output logic ready_out
);
   import flpc_pkg::*;

   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic read_seen_r;
   logic addr_ok;
   logic wr_go;
   logic skip_busy_r;
   logic skip_go;
   logic [7:0] rx_status_fill_r;
   logic [15:0] rx_data_fill_r;
   logic [7:0] tx_status_fill_r;
   logic [15:0] tx_data_room_r;
   logic [15:0] rx_data_fill_nxt;
   logic [15:0] rx_frame_words;
   logic [15:0] rx_pop_bytes;
   logic [15:0] rx_skip_bytes;
   flpc_pm_e power_state_select_r;
   logic [4:0] settle_cnt_r;
   logic ready_r;
   logic xrst_busy;
   logic xrst_go;
   logic wake_frame_enable_r;
   logic energy_detect_enable_r;
   logic wake_output_drive_type_r;
   logic wake_output_pulse_select_r;
   logic wake_output_polarity_r;
   logic wake_output_enable_r;
   logic probe_wake;
   logic [31:0] rdata;
   logic [31:0] xrst_len_r;

   flpc_wake_if wif ();

   ////////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, always okay

   assign addr_ok = hsel_in && htrans_in[1] && hready_in;
   assign wr_go = wr_pend_r && read_seen_r;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         wr_pend_r <= addr_ok && hwrite_in;
         if (addr_ok) begin
            wr_addr_r <= haddr_in[7:0];
         end
      end
   end

   // a read is needed after reset or wake before writes take effect
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         read_seen_r <= 1'b0;
      end else if (addr_ok && !hwrite_in) begin
         read_seen_r <= 1'b1;
      end else if (probe_wake) begin
         read_seen_r <= 1'b0;
      end
   end

   always_comb begin
      rdata = 32'h0;
      unique case (haddr_in[7:0])
         OFS_RX_DATAPATH_CONTROL: rdata[BIT_RX_SKIP_FRAME] = skip_busy_r;
         OFS_RX_FIFO_OCCUPANCY: rdata = {8'h00, rx_status_fill_r, rx_data_fill_r};
         OFS_TX_FIFO_OCCUPANCY: rdata = {8'h00, tx_status_fill_r, tx_data_room_r};
         OFS_POWER_MANAGEMENT_CONTROL: begin
            rdata[LSB_POWER_STATE_SELECT +: 2] = power_state_select_r;
            rdata[BIT_TRANSCEIVER_RESET] = xrst_busy;
            rdata[BIT_WAKE_FRAME_ENABLE] = wake_frame_enable_r;
            rdata[BIT_ENERGY_DETECT_ENABLE] = energy_detect_enable_r;
            rdata[BIT_WAKE_OUTPUT_DRIVE_TYPE] = wake_output_drive_type_r;
            rdata[BIT_WAKE_OUTPUT_PULSE_SELECT] = wake_output_pulse_select_r;
            rdata[BIT_WAKE_OUTPUT_POLARITY] = wake_output_polarity_r;
            rdata[BIT_WAKE_OUTPUT_ENABLE] = wake_output_enable_r;
            rdata[BIT_DEVICE_READY] = ready_r;
         end
         default: rdata = 32'h0;
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hrdata_out <= 32'h0;
      end else if (addr_ok && !hwrite_in) begin
         hrdata_out <= rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // receive skip

   assign skip_go = wr_go && (wr_addr_r == OFS_RX_DATAPATH_CONTROL) && hwdata_in[BIT_RX_SKIP_FRAME] && !skip_busy_r;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         skip_busy_r <= 1'b0;
         rx_skip_req_out <= 1'b0;
      end else begin
         rx_skip_req_out <= skip_go;
         if (skip_go) begin
            skip_busy_r <= 1'b1;
         end else if (rx_skip_done_in) begin
            skip_busy_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fifo fill levels

   assign rx_frame_words = {rx_frame_len_in[15:2] + {13'h0, |rx_frame_len_in[1:0]}, 2'b00};
   assign rx_pop_bytes = rx_data_pop_in ? FILL_WORD_BYTES : 16'h0;
   assign rx_skip_bytes = (skip_busy_r && rx_skip_done_in) ? rx_skip_len_in : 16'h0;
   assign rx_data_fill_nxt = rx_data_fill_r + (rx_frame_in ? rx_frame_words : 16'h0) - rx_pop_bytes - rx_skip_bytes;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_data_fill_r <= RST_RX_DATA_FILL;
      end else begin
         rx_data_fill_r <= rx_data_fill_nxt;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_status_fill_r <= RST_STATUS_FILL;
         tx_status_fill_r <= RST_STATUS_FILL;
      end else begin
         rx_status_fill_r <= rx_status_fill_r + {7'h0, rx_status_push_in} - {7'h0, rx_status_pop_in};
         tx_status_fill_r <= tx_status_fill_r + {7'h0, tx_status_push_in} - {7'h0, tx_status_pop_in};
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_data_room_r <= RST_TX_DATA_ROOM;
      end else begin
         tx_data_room_r <= tx_data_room_r + (tx_data_drain_in ? FILL_WORD_BYTES : 16'h0)
            - (tx_data_push_in ? FILL_WORD_BYTES : 16'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power state, wake by probe write and ready flag

   assign probe_wake = wr_go && (wr_addr_r == OFS_ENDIAN_PROBE) && (power_state_select_r != FLPC_PM_NORMAL);

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         power_state_select_r <= FLPC_PM_NORMAL;
      end else if (probe_wake) begin
         power_state_select_r <= FLPC_PM_NORMAL;
      end else if (wr_go && wr_addr_r == OFS_POWER_MANAGEMENT_CONTROL && power_state_select_r == FLPC_PM_NORMAL) begin
         power_state_select_r <= flpc_pm_e'(hwdata_in[LSB_POWER_STATE_SELECT +: 2]);
      end
   end

   // ready rises a fixed settle time after reset or wake, drops while asleep
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         settle_cnt_r <= 5'h0;
         ready_r <= 1'b0;
      end else if (probe_wake || power_state_select_r != FLPC_PM_NORMAL) begin
         settle_cnt_r <= 5'h0;
         ready_r <= 1'b0;
      end else if (settle_cnt_r == SETTLE_CNT_MAX) begin
         ready_r <= 1'b1;
      end else begin
         settle_cnt_r <= settle_cnt_r + 5'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power management control fields

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wake_frame_enable_r <= 1'b0;
         energy_detect_enable_r <= 1'b0;
         wake_output_drive_type_r <= 1'b0;
         wake_output_pulse_select_r <= 1'b0;
         wake_output_polarity_r <= 1'b0;
         wake_output_enable_r <= 1'b0;
      end else if (wr_go && wr_addr_r == OFS_POWER_MANAGEMENT_CONTROL) begin
         wake_frame_enable_r <= hwdata_in[BIT_WAKE_FRAME_ENABLE];
         energy_detect_enable_r <= hwdata_in[BIT_ENERGY_DETECT_ENABLE];
         wake_output_drive_type_r <= hwdata_in[BIT_WAKE_OUTPUT_DRIVE_TYPE];
         wake_output_pulse_select_r <= hwdata_in[BIT_WAKE_OUTPUT_PULSE_SELECT];
         wake_output_polarity_r <= hwdata_in[BIT_WAKE_OUTPUT_POLARITY];
         wake_output_enable_r <= hwdata_in[BIT_WAKE_OUTPUT_ENABLE];
      end
   end

   // transceiver reset: a write while busy is ignored by the timer
   assign xrst_go = wr_go && wr_addr_r == OFS_POWER_MANAGEMENT_CONTROL && hwdata_in[BIT_TRANSCEIVER_RESET];

   flpc_hold_timer #(.CYCLES(XRST_CYC)) u_xrst (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .start_in(xrst_go),
      .busy_out(xrst_busy)
   );

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         transceiver_reset_out <= 1'b0;
         power_state_out <= 2'b00;
         ready_out <= 1'b0;
      end else begin
         transceiver_reset_out <= xrst_busy;
         power_state_out <= power_state_select_r;
         ready_out <= ready_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // wake output

   assign wif.ev_frame = wake_frame_event_in;
   assign wif.ev_energy = energy_event_in;
   assign wif.frame_en = wake_frame_enable_r;
   assign wif.energy_en = energy_detect_enable_r;
   assign wif.out_en = wake_output_enable_r;
   assign wif.pulse_sel = wake_output_pulse_select_r;
   assign wif.polarity = wake_output_polarity_r;
   assign wif.push_pull = wake_output_drive_type_r;

   flpc_wake #(.PULSE_CYC(PULSE_CYC)) u_wake (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .wif(wif.wake)
   );

   assign wake_pin_out = wif.pin_level;
   assign wake_pin_oe_out = wif.pin_oe;
   assign wake_interrupt_out = wif.irq;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   // running length of the current transceiver reset, zero while it is off
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         xrst_len_r <= 32'h0;
      end else if (!transceiver_reset_out) begin
         xrst_len_r <= 32'h0;
      end else begin
         xrst_len_r <= xrst_len_r + 32'h1;
      end
   end

   a_skip_start: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      skip_go |=> rx_skip_req_out && skip_busy_r ##1 !rx_skip_req_out)
      else $error("skip request not issued as one pulse");
   a_skip_self_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      skip_busy_r && rx_skip_done_in && !skip_go |=> !skip_busy_r)
      else $error("skip bit did not clear on completion");
   a_rx_fill_add: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      rx_frame_in && !rx_data_pop_in && !rx_skip_done_in
      |=> rx_data_fill_r == $past(rx_data_fill_r) + $past(rx_frame_words))
      else $error("rx data fill did not grow by rounded length");
   a_tx_room_drop: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      tx_data_push_in && !tx_data_drain_in |=> tx_data_room_r == $past(tx_data_room_r) - 16'h4)
      else $error("tx data room did not drop by one word");
   a_write_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_pend_r && !read_seen_r |=> $stable(wake_frame_enable_r) && $stable(power_state_select_r))
      else $error("write took effect before any read");
   a_xrst_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $fell(transceiver_reset_out) |-> $past(xrst_len_r) >= 32'(XRST_CYC - 1))
      else $error("transceiver reset held too short");
   a_probe_wake: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      probe_wake |=> power_state_select_r == FLPC_PM_NORMAL && !ready_r && (!read_seen_r || $past(addr_ok && !hwrite_in)))
      else $error("probe write did not wake the device");
   a_wake_irq: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wake_frame_enable_r && wake_frame_event_in ##1 wake_frame_enable_r |-> ##1 wake_interrupt_out)
      else $error("wake interrupt not raised");
   a_open_drain: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !$past(wake_output_drive_type_r) |-> !wake_pin_out)
      else $error("open drain pin driven high");
endmodule // flpc_top

// *** testbench/flpc_skip_model.sv ***
// far-side model of the rx data fifo answering skip requests
module flpc_skip_model #(
   parameter int DELAY = 8,
   parameter logic [15:0] LEN = 16'h0004
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic skip_req_in,
   output logic skip_done_out,
   output logic [15:0] skip_len_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // a request starts a countdown; done pulses one cycle when it runs out
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt <= 0;
         skip_done_out <= 1'b0;
      end else begin
         skip_done_out <= (cnt == 1);
         if (skip_req_in) begin
            cnt <= DELAY;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
      end
   end
   // the length is only qualified by done; otherwise it shows the inverse
   assign skip_len_out = skip_done_out ? LEN : ~LEN;
endmodule // flpc_skip_model

// *** testbench/tb_fifo_level_and_power_control.sv ***
// bench for the fifo level and power control register bank
module tb_fifo_level_and_power_control;
   timeunit 1ns;
   timeprecision 1ps;
   import flpc_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [9:0] ev = 10'h000;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout;
   logic hresp;
   logic [15:0] flen = 16'h0005;
   logic skip_req;
   logic skip_done;
   logic [15:0] skip_len;
   logic wake_pin;
   logic wake_oe;
   logic wake_irq;
   logic xrst;
   logic ready;
   logic [1:0] pstate;
   int n_fail = 0;
   int comparisons = 0;
   int xcnt = 0;
   int fifo_seq[11] = '{0, 1, 2, 2, 3, 4, 4, 5, 6, 6, 7};
   ////////////////////////////////////////////////////////////////////////////////
   flpc_top #(.XRST_CYC(20), .PULSE_CYC(10)) flpc_top_inst (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hreadyout),
      .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp), .rx_frame_in(ev[0]),
      .rx_frame_len_in(flen), .rx_data_pop_in(ev[1]), .rx_status_push_in(ev[2]),
      .rx_status_pop_in(ev[3]), .tx_data_push_in(ev[4]), .tx_data_drain_in(ev[5]),
      .tx_status_push_in(ev[6]), .tx_status_pop_in(ev[7]), .rx_skip_req_out(skip_req),
      .rx_skip_done_in(skip_done), .rx_skip_len_in(skip_len), .wake_frame_event_in(ev[8]),
      .energy_event_in(ev[9]), .wake_pin_out(wake_pin), .wake_pin_oe_out(wake_oe),
      .wake_interrupt_out(wake_irq), .transceiver_reset_out(xrst), .power_state_out(pstate),
      .ready_out(ready));
   flpc_skip_model flpc_skip_model_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .skip_req_in(skip_req), .skip_done_out(skip_done), .skip_len_out(skip_len));
   initial begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      if (xrst === 1'b1) xcnt <= xcnt + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one single ahb transfer; read data lands in rd
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge ref_clk_in);
      while (hreadyout !== 1'b1) @(posedge ref_clk_in);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge ref_clk_in);
      while (hreadyout !== 1'b1) @(posedge ref_clk_in);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic wait_ready();
      rd = 32'h0;
      for (int i = 0; i < 60 && rd[0] !== 1'b1; i++) xfer(1'b0, OFS_POWER_MANAGEMENT_CONTROL, 32'h0);
   endtask
   task automatic pulse(input int i);
      @(posedge ref_clk_in);
      ev[i] <= 1'b1;
      @(posedge ref_clk_in);
      ev[i] <= 1'b0;
   endtask
   task automatic settle_wake(input int i, input logic [31:0] exp);
      pulse(i);
      repeat (2) @(posedge ref_clk_in);
      chk({29'h0, wake_irq, wake_oe, wake_pin}, exp);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #300us;
      n_fail++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0000_0246);
      rchk(OFS_RX_FIFO_OCCUPANCY, 32'h0);
      rchk(OFS_TX_FIFO_OCCUPANCY, 32'h0000_1200);
      rchk(8'h90, 32'h0);
      wait_ready();
      chk(rd, 32'h0000_0001);
      for (int i = 0; i < 11; i++) pulse(fifo_seq[i]);
      rchk(OFS_RX_FIFO_OCCUPANCY, 32'h0001_0004);
      rchk(OFS_TX_FIFO_OCCUPANCY, 32'h0001_11fc);
      xfer(1'b1, OFS_RX_DATAPATH_CONTROL, 32'h8000_0000);
      rchk(OFS_RX_DATAPATH_CONTROL, 32'h8000_0000);
      // no rx data pops are issued while a skip runs
      for (int i = 0; i < 20 && rd[31] !== 1'b0; i++) xfer(1'b0, OFS_RX_DATAPATH_CONTROL, 32'h0);
      chk(rd, 32'h0);
      rchk(OFS_RX_FIFO_OCCUPANCY, 32'h0001_0000);
      flen <= 16'h000c;
      pulse(0);
      rchk(OFS_RX_FIFO_OCCUPANCY, 32'h0001_000c);
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0000_0400);
      rchk(OFS_POWER_MANAGEMENT_CONTROL, 32'h0000_0401);
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0000_0400);
      repeat (40) @(posedge ref_clk_in);
      chk(xcnt, 32'd20);
      rchk(OFS_POWER_MANAGEMENT_CONTROL, 32'h0000_0001);
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0000_0246);
      settle_wake(8, 32'h7);
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0);
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0000_024e);
      settle_wake(8, 32'h7);
      // the pulse stands exactly the configured number of cycles
      repeat (9) @(posedge ref_clk_in);
      chk({31'h0, wake_pin}, 32'h1);
      @(posedge ref_clk_in);
      chk({31'h0, wake_pin}, 32'h0);
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0);
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0000_0100);
      settle_wake(9, 32'h4);
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0000_0106);
      repeat (2) @(posedge ref_clk_in);
      chk({29'h0, wake_irq, wake_oe, wake_pin}, 32'h6);
      xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, 32'h0);
      for (int m = 1; m < 3; m++) begin
         xfer(1'b1, OFS_POWER_MANAGEMENT_CONTROL, {18'h0, m[1:0], 12'h000});
         repeat (2) @(posedge ref_clk_in);
         chk({30'h0, pstate}, m);
         rchk(OFS_POWER_MANAGEMENT_CONTROL, {18'h0, m[1:0], 12'h000});
         xfer(1'b1, OFS_ENDIAN_PROBE, 32'h0);
         repeat (2) @(posedge ref_clk_in);
         chk({30'h0, pstate}, 32'h0);
         chk({31'h0, ready}, 32'h0);
         wait_ready();
         chk(rd, 32'h0000_0001);
      end
      conclude();
   end
endmodule // tb_fifo_level_and_power_control
